// >>> design/deb_cfg.svh
// constants for the dma endpoint and burst configuration block
`ifndef DEB_CFG_SVH
`define DEB_CFG_SVH

// register byte addresses
`define DEB_ADDR_REASON 8'h50
`define DEB_ADDR_ENABLE 8'h54
`define DEB_ADDR_ENDP 8'h58
`define DEB_ADDR_BURST 8'h64

// reason and enable bit positions (same layout in both)
`define DEB_BIT_STOP 12
`define DEB_BIT_SHORT 10
`define DEB_BIT_DONE 8
`define DEB_IRQ_MASK 16'h1500

// endpoint register fields
`define DEB_EP_MSB 3
`define DEB_EP_LSB 1
`define DEB_DIR_BIT 0

// burst length field and reset values
`define DEB_BURST_MSB 12
`define DEB_BURST_LSB 0
`define DEB_ENABLE_RST 16'h0000
`define DEB_REASON_RST 16'h0000
`define DEB_ENDP_RST 4'h0
`define DEB_BURST_RST 13'h0004

// bytes moved per bus strobe in each bus mode
`define DEB_STEP_WORD 14'h0002
`define DEB_STEP_BYTE 14'h0001

`endif

// >>> design/deb_pkg.sv
// types shared by the dma endpoint and burst configuration block
`include "deb_cfg.svh"
package deb_pkg;

  // one-hot states of the burst request sequencer
  typedef enum logic [2:0]
  {
    DEB_IDLE = 3'b001,
    DEB_REQ = 3'b010,
    DEB_GAP = 3'b100
  } deb_burst_st_t;

  // complete state of the burst sequencer
  typedef struct packed
  {
    deb_burst_st_t st;
    logic [13:0] cnt;
    logic req;
  } deb_burst_state_t;

  // complete state of the register block
  typedef struct packed
  {
    logic [15:0] reason;
    logic [15:0] enable;
    logic [3:0] endp;
    logic [12:0] burst;
    logic [15:0] rdata;
    logic irq;
  } deb_top_state_t;

endpackage : deb_pkg

// >>> design/deb_reset_sync.sv
// reset release synchroniser
`timescale 1ns/1ps
module deb_reset_sync
(
  input wire logic clk,
  input wire logic rst_n,
  output logic rst_sync_n
);
  // two stage shift register, all state in one vector
  logic [1:0] sr_q;
  logic [1:0] sr_d;

  // shift in ones after release; assert is immediate
  always_comb
  begin
    sr_d = {sr_q[0], 1'b1};
  end

  // asynchronous assert, synchronous release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sr_q <= 2'h0;
    else
      sr_q <= sr_d;
  end

  assign rst_sync_n = sr_q[1];
endmodule : deb_reset_sync

// >>> design/deb_burst_seq.sv
// burst byte counter driving the transfer request line
`timescale 1ns/1ps
`include "deb_cfg.svh"
module deb_burst_seq
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_reset,
  input wire logic run,
  input wire logic xfer_strobe,
  input wire logic word_mode,
  input wire logic [12:0] burst_length,
  output logic request
);
  deb_pkg::deb_burst_state_t q, d;
  logic [13:0] sum;

  // next state: count bytes, drop request at the burst length
  always_comb
  begin
    d = q;
    sum = q.cnt + (word_mode ? `DEB_STEP_WORD : `DEB_STEP_BYTE);
    case (q.st)
      deb_pkg::DEB_IDLE:
      begin
        d.cnt = 14'h0000;
        d.req = run;
        if (run)
          d.st = deb_pkg::DEB_REQ;
      end
      deb_pkg::DEB_REQ:
      begin
        if (!run)
        begin
          d.st = deb_pkg::DEB_IDLE;
          d.req = 1'b0;
          d.cnt = 14'h0000;
        end
        else if (xfer_strobe && sum >= {1'b0, burst_length})
        begin
          // two low cycles, gap then idle, let the far end see the drop
          d.st = deb_pkg::DEB_GAP;
          d.req = 1'b0;
          d.cnt = 14'h0000;
        end
        else if (xfer_strobe)
          d.cnt = sum;
      end
      deb_pkg::DEB_GAP:
      begin
        d.st = deb_pkg::DEB_IDLE;
        d.req = 1'b0;
      end
      default:
      begin
        d.st = deb_pkg::DEB_IDLE;
        d.req = 1'b0;
        d.cnt = 14'h0000;
      end
    endcase
    // usb bus reset aborts any burst in flight
    if (bus_reset)
    begin
      d.st = deb_pkg::DEB_IDLE;
      d.req = 1'b0;
      d.cnt = 14'h0000;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= {deb_pkg::DEB_IDLE, 14'h0000, 1'b0};
    else
      q <= d;
  end

  assign request = q.req;

  // request drops the cycle after the burst byte count is reached
  property p_burst_drop;
    @(posedge clk) disable iff (!rst_n)
    (q.st == deb_pkg::DEB_REQ && run && xfer_strobe
      && sum >= {1'b0, burst_length}) |=> !request ##1 !request;
  endproperty
  a_burst_drop: assert property (p_burst_drop)
    else $error("request not dropped at burst length");
endmodule : deb_burst_seq

// >>> design/deb_dma_cfg.sv
// dma interrupt enable, endpoint select and burst length registers
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "deb_cfg.svh"
module deb_dma_cfg
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic usb_bus_reset,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic stop_reason_event,
  input wire logic short_end_event,
  input wire logic count_zero_event,
  input wire logic dma_run,
  input wire logic xfer_strobe,
  input wire logic word_mode,
  output logic [2:0] endpoint_select,
  output logic transfer_direction,
  output logic transfer_request_line,
  output logic dma_irq
);
  // synchronised reset used everywhere below
  logic rst_sync_n;

  // register state and its next value
  deb_pkg::deb_top_state_t q;
  deb_pkg::deb_top_state_t d;

  // one-hot register selects for reads and writes
  logic [3:0] wr_sel;
  logic [3:0] rd_sel;

  // bits hardware sets this cycle
  logic [15:0] reason_set;

  // bits cleared this cycle by software
  logic [15:0] reason_clr;

  // address decode, shared by the read and the write path
  function automatic logic [3:0] decode
  (
    input logic [7:0] addr
  );
    logic [3:0] sel;
    sel = 4'h0;
    case (addr)
      `DEB_ADDR_REASON: sel = 4'h1;
      `DEB_ADDR_ENABLE: sel = 4'h2;
      `DEB_ADDR_ENDP: sel = 4'h4;
      `DEB_ADDR_BURST: sel = 4'h8;
      // unmapped: nothing selected, reads give zero
      default: sel = 4'h0;
    endcase
    return sel;
  endfunction : decode

  // reset release through two flops
  deb_reset_sync u_rst
  (
    .clk(clk),
    .rst_n(rst_n),
    .rst_sync_n(rst_sync_n)
  );

  // burst sequencer follows the stored length
  // a length written mid-burst takes effect from the next strobe, so
  // software should only change it while no burst is running
  deb_burst_seq u_burst
  (
    .clk(clk),
    .rst_n(rst_sync_n),
    .bus_reset(usb_bus_reset),
    .run(dma_run),
    .xfer_strobe(xfer_strobe),
    .word_mode(word_mode),
    .burst_length(q.burst),
    .request(transfer_request_line)
  );

  // strobes never overlap, so decode is gated by each
  // each decode only has to look at its own strobe
  assign wr_sel = reg_wr ? decode(reg_addr) : 4'h0;
  assign rd_sel = reg_rd ? decode(reg_addr) : 4'h0;

  // next state of every register
  always_comb
  begin
    d = q;
    // read data live for one cycle only
    d.rdata = 16'h0000;
    // hardware events, one per reason bit
    reason_set = 16'h0000;
    reason_set[`DEB_BIT_STOP] = stop_reason_event;
    reason_set[`DEB_BIT_SHORT] = short_end_event;
    reason_set[`DEB_BIT_DONE] = count_zero_event;
    // write one clears a bit; a read clears the whole register
    reason_clr = 16'h0000;
    if (wr_sel[0])
      reason_clr = reg_wdata & `DEB_IRQ_MASK;
    if (rd_sel[0])
      reason_clr = `DEB_IRQ_MASK;
    // set wins over clear, so no event is lost
    // software must act on what it read: a flag raised in the read
    // cycle itself survives and shows up on the next read
    d.reason = (q.reason & ~reason_clr) | reason_set;
    // enables keep only the three defined bits
    if (wr_sel[1])
      d.enable = reg_wdata & `DEB_IRQ_MASK;
    // endpoint index and direction
    if (wr_sel[2])
      d.endp = reg_wdata[`DEB_EP_MSB:`DEB_DIR_BIT];
    // burst length, 13 bits
    if (wr_sel[3])
      d.burst = reg_wdata[`DEB_BURST_MSB:`DEB_BURST_LSB];
    // read mux; reserved bits read as zero
    case (rd_sel)
      4'h1: d.rdata = q.reason;
      4'h2: d.rdata = q.enable;
      4'h4: d.rdata = {12'h000, q.endp};
      4'h8: d.rdata = {3'h0, q.burst};
      default: d.rdata = 16'h0000;
    endcase
    // usb bus reset restores every reset value
    if (usb_bus_reset)
    begin
      d.reason = `DEB_REASON_RST;
      d.enable = `DEB_ENABLE_RST;
      d.endp = `DEB_ENDP_RST;
      d.burst = `DEB_BURST_RST;
    end
    // single level irq from the new state, so it tracks the flags
    // this saves a cycle of latency at the price of a longer path
    // from the strobes and events to the irq flop
    d.irq = |(d.reason & d.enable);
  end

  // all block state in one register
  // read data and irq have no stored value to restore, they are
  // simply forced quiet while reset stands
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      q.reason <= `DEB_REASON_RST;
      q.enable <= `DEB_ENABLE_RST;
      q.endp <= `DEB_ENDP_RST;
      q.burst <= `DEB_BURST_RST;
      q.rdata <= 16'h0000;
      q.irq <= 1'b0;
    end
    else
      q <= d;
  end

  // outputs come straight from the state flops
  assign reg_rdata = q.rdata;
  assign endpoint_select = q.endp[`DEB_EP_MSB:`DEB_EP_LSB];
  assign transfer_direction = q.endp[`DEB_DIR_BIT];
  assign dma_irq = q.irq;

  // no enabled reason, no interrupt
  property p_irq_gated;
    @(posedge clk) disable iff (!rst_sync_n)
    (!reg_wr && (q.enable == 16'h0000)) |=> !dma_irq;
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("irq raised with all enables off");

  // bus reset restores all enables and the burst length
  property p_bus_reset;
    @(posedge clk) disable iff (!rst_sync_n)
    usb_bus_reset |=> (q.enable == `DEB_ENABLE_RST)
      && (q.reason == `DEB_REASON_RST)
      && (q.burst == `DEB_BURST_RST) && !dma_irq
      && ({endpoint_select, transfer_direction} == `DEB_ENDP_RST)
      && !transfer_request_line;
  endproperty
  a_bus_reset: assert property (p_bus_reset)
    else $error("bus reset did not restore registers");

  // stop event with its enable set raises irq next cycle
  property p_stop_irq;
    @(posedge clk) disable iff (!rst_sync_n)
    (stop_reason_event && q.enable[`DEB_BIT_STOP] && !usb_bus_reset
      && !(reg_wr && reg_addr == `DEB_ADDR_ENABLE)) |=> dma_irq;
  endproperty
  a_stop_irq: assert property (p_stop_irq)
    else $error("stop reason did not raise irq");

  // short end event with its enable set raises irq
  property p_short_irq;
    @(posedge clk) disable iff (!rst_sync_n)
    (short_end_event && q.enable[`DEB_BIT_SHORT] && !usb_bus_reset
      && !(reg_wr && reg_addr == `DEB_ADDR_ENABLE)) |=> dma_irq;
  endproperty
  a_short_irq: assert property (p_short_irq)
    else $error("short end reason did not raise irq");

  // done event with its enable set raises irq
  property p_done_irq;
    @(posedge clk) disable iff (!rst_sync_n)
    (count_zero_event && q.enable[`DEB_BIT_DONE] && !usb_bus_reset
      && !(reg_wr && reg_addr == `DEB_ADDR_ENABLE)) |=> dma_irq;
  endproperty
  a_done_irq: assert property (p_done_irq)
    else $error("done reason did not raise irq");

  // endpoint write shows on the select outputs next cycle
  property p_endp_write;
    @(posedge clk) disable iff (!rst_sync_n)
    (reg_wr && reg_addr == `DEB_ADDR_ENDP && !usb_bus_reset)
      |=> (endpoint_select == $past(reg_wdata[`DEB_EP_MSB:`DEB_EP_LSB]))
      && (transfer_direction == $past(reg_wdata[`DEB_DIR_BIT]));
  endproperty
  a_endp_write: assert property (p_endp_write)
    else $error("endpoint select not updated");

  // direction holds between endpoint writes
  property p_dir_hold;
    @(posedge clk) disable iff (!rst_sync_n)
    !(reg_wr && reg_addr == `DEB_ADDR_ENDP) && !usb_bus_reset
      |=> $stable(transfer_direction);
  endproperty
  a_dir_hold: assert property (p_dir_hold)
    else $error("direction changed without a write");

  // burst write reads back as 13 bits two cycles on
  property p_burst_rb;
    @(posedge clk) disable iff (!rst_sync_n)
    (reg_wr && reg_addr == `DEB_ADDR_BURST && !usb_bus_reset)
      ##1 (reg_rd && reg_addr == `DEB_ADDR_BURST && !usb_bus_reset)
      |=> reg_rdata
        == {3'h0, $past(reg_wdata[`DEB_BURST_MSB:`DEB_BURST_LSB], 2)};
  endproperty
  a_burst_rb: assert property (p_burst_rb)
    else $error("burst length readback wrong");

  // counter zero sets the done flag even under a clear
  property p_done_set;
    @(posedge clk) disable iff (!rst_sync_n)
    (count_zero_event && !usb_bus_reset) |=> q.reason[`DEB_BIT_DONE];
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("done flag not set");

  // write one clears the done flag when no event competes
  property p_done_clr;
    @(posedge clk) disable iff (!rst_sync_n)
    (reg_wr && reg_addr == `DEB_ADDR_REASON && reg_wdata[`DEB_BIT_DONE]
      && !count_zero_event) |=> !q.reason[`DEB_BIT_DONE];
  endproperty
  a_done_clr: assert property (p_done_clr)
    else $error("done flag not cleared by write");

  // irq follows the enabled reasons each cycle
  property p_irq_or;
    @(posedge clk) disable iff (!rst_sync_n)
    ##1 (dma_irq == |(q.reason & q.enable));
  endproperty
  a_irq_or: assert property (p_irq_or)
    else $error("irq not the or of enabled reasons");

  // enable writes keep the three defined bits only
  property p_enable_write;
    @(posedge clk) disable iff (!rst_sync_n)
    (reg_wr && reg_addr == `DEB_ADDR_ENABLE && !usb_bus_reset)
      |=> q.enable == ($past(reg_wdata) & `DEB_IRQ_MASK);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable register not written as expected");

  // a lone stop event with its enable off raises no irq
  property p_stop_gated;
    @(posedge clk) disable iff (!rst_sync_n)
    (stop_reason_event && q.reason == `DEB_REASON_RST
      && !q.enable[`DEB_BIT_STOP] && !short_end_event && !count_zero_event
      && !(reg_wr && reg_addr == `DEB_ADDR_ENABLE)) |=> !dma_irq;
  endproperty
  a_stop_gated: assert property (p_stop_gated)
    else $error("stop reason raised irq while disabled");

  // a lone short end event with its enable off raises no irq
  property p_short_gated;
    @(posedge clk) disable iff (!rst_sync_n)
    (short_end_event && q.reason == `DEB_REASON_RST
      && !q.enable[`DEB_BIT_SHORT] && !stop_reason_event && !count_zero_event
      && !(reg_wr && reg_addr == `DEB_ADDR_ENABLE)) |=> !dma_irq;
  endproperty
  a_short_gated: assert property (p_short_gated)
    else $error("short end reason raised irq while disabled");

  // a lone done event with its enable off raises no irq
  property p_done_gated;
    @(posedge clk) disable iff (!rst_sync_n)
    (count_zero_event && q.reason == `DEB_REASON_RST
      && !q.enable[`DEB_BIT_DONE] && !stop_reason_event && !short_end_event
      && !(reg_wr && reg_addr == `DEB_ADDR_ENABLE)) |=> !dma_irq;
  endproperty
  a_done_gated: assert property (p_done_gated)
    else $error("done reason raised irq while disabled");

  // read of the reason register clears it when no event competes
  property p_reason_rd_clr;
    @(posedge clk) disable iff (!rst_sync_n)
    (reg_rd && reg_addr == `DEB_ADDR_REASON && !stop_reason_event
      && !short_end_event && !count_zero_event)
      |=> q.reason == `DEB_REASON_RST;
  endproperty
  a_reason_rd_clr: assert property (p_reason_rd_clr)
    else $error("reason register not cleared by read");

  // endpoint index holds between endpoint writes
  property p_endp_hold;
    @(posedge clk) disable iff (!rst_sync_n)
    !(reg_wr && reg_addr == `DEB_ADDR_ENDP) && !usb_bus_reset
      |=> $stable(endpoint_select);
  endproperty
  a_endp_hold: assert property (p_endp_hold)
    else $error("endpoint select changed without a write");

  // burst length holds between burst writes
  property p_burst_hold;
    @(posedge clk) disable iff (!rst_sync_n)
    !(reg_wr && reg_addr == `DEB_ADDR_BURST) && !usb_bus_reset
      |=> $stable(q.burst);
  endproperty
  a_burst_hold: assert property (p_burst_hold)
    else $error("burst length changed without a write");

endmodule : deb_dma_cfg

// >>> test/deb_dma_host_model.sv
// behavioural external dma controller answering the request line
`timescale 1ns/1ps
module deb_dma_host_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic request,
  input wire logic slow,
  output logic xfer_strobe,
  output logic [7:0] taken
);
  // toggles so slow mode strobes every other cycle
  logic phase;

  // strobe while request stands; count only strobes the device saw
  // while still requesting, since a late one is ignored by it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xfer_strobe <= 1'b0;
      taken <= 8'h00;
      phase <= 1'b0;
    end
    else
    begin
      phase <= ~phase;
      xfer_strobe <= request && (!slow || phase);
      if (xfer_strobe && request)
        taken <= taken + 8'h01;
    end
  end
endmodule : deb_dma_host_model

// >>> test/tb_top.sv
// self-checking bench of the dma configuration block
`timescale 1ns/1ps
`include "deb_cfg.svh"
module tb_top;
  logic clk, rst_n, bus_rst, reg_wr, reg_rd, dma_run, word_mode, slow;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic stop_ev, short_ev, done_ev, xfer_strobe;
  logic [2:0] ep;
  logic dir, req, irq;
  logic [7:0] taken;
  int fail_count, n_checks;

  deb_dma_cfg i_dut
  (
    .clk(clk), .rst_n(rst_n), .usb_bus_reset(bus_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stop_reason_event(stop_ev), .short_end_event(short_ev),
    .count_zero_event(done_ev), .dma_run(dma_run),
    .xfer_strobe(xfer_strobe), .word_mode(word_mode),
    .endpoint_select(ep), .transfer_direction(dir),
    .transfer_request_line(req), .dma_irq(irq)
  );

  // far side of the request line
  deb_dma_host_model i_host
  (
    .clk(clk), .rst_n(rst_n), .request(req), .slow(slow),
    .xfer_strobe(xfer_strobe), .taken(taken)
  );

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // print counts and verdict, then stop
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // write followed at once by a read of the same place
  task automatic wrrd(input logic [7:0] a, input logic [15:0] d,
                      input logic [15:0] exp);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : wrrd

  // one-cycle read strobe, data looked at in the following cycle only
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rdchk

  // pulse event inputs {stop, short end, count zero}
  task automatic ev(input logic [2:0] e);
    @(posedge clk);
    {stop_ev, short_ev, done_ev} <= e;
    @(posedge clk);
    {stop_ev, short_ev, done_ev} <= 3'b000;
    #1;
  endtask : ev

  // bounded wait for the request line to reach a level
  task automatic wait_req(input logic lvl);
    int i;
    for (i = 0; i < 300 && req !== lvl; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (req !== lvl)
    begin
      fail_count++;
      conclude();
    end
  endtask : wait_req

  // one burst: strobes taken, gap length, stop on run low
  task automatic burst(input logic [15:0] len, input logic wm,
                       input logic sl, input logic [7:0] n);
    logic [7:0] t0;
    wr(`DEB_ADDR_BURST, len);
    @(posedge clk);
    word_mode <= wm;
    slow <= sl;
    dma_run <= 1'b1;
    t0 = taken;
    wait_req(1'b1);
    wait_req(1'b0);
    chk(taken - t0, n);
    @(posedge clk);
    #1;
    chk(req, 1'b0);
    @(posedge clk);
    dma_run <= 1'b0;
    #1;
    chk(req, 1'b1);
    @(posedge clk);
    #1;
    chk(req, 1'b0);
  endtask : burst

  // main sequence
  initial
  begin
    logic [15:0] m;
    logic [2:0] e;
    {rst_n, bus_rst, reg_wr, reg_rd, dma_run, word_mode, slow} = 7'h00;
    {stop_ev, short_ev, done_ev, reg_addr, reg_wdata} = 27'h0;
    fail_count = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // reset values and unmapped place
    rdchk(`DEB_ADDR_ENABLE, 16'h0000);
    rdchk(`DEB_ADDR_REASON, 16'h0000);
    rdchk(`DEB_ADDR_ENDP, 16'h0000);
    rdchk(`DEB_ADDR_BURST, 16'h0004);
    rdchk(8'h70, 16'h0000);
    // defined bits only, reserved bits written as zero
    wr(`DEB_ADDR_ENABLE, 16'h1500);
    rdchk(`DEB_ADDR_ENABLE, 16'h1500);
    wrrd(`DEB_ADDR_BURST, 16'h1FFF, 16'h1FFF);
    @(posedge clk);
    #1;
    chk(reg_rdata, 16'h0000);
    // every endpoint and direction
    for (int k = 0; k < 16; k++)
    begin
      wr(`DEB_ADDR_ENDP, 16'(k));
      chk({12'h000, ep, dir}, 16'(k));
      rdchk(`DEB_ADDR_ENDP, 16'(k));
    end
    // each reason gated by its own enable bit only
    for (int b = 0; b < 3; b++)
    begin
      e = 3'b100 >> b;
      m = 16'h1000 >> (2 * b);
      wr(`DEB_ADDR_ENABLE, 16'h1500 & ~m);
      ev(e);
      chk(irq, 1'b0);
      rdchk(`DEB_ADDR_REASON, m);
      wr(`DEB_ADDR_ENABLE, m);
      ev(e);
      chk(irq, 1'b1);
      rdchk(`DEB_ADDR_REASON, m);
      chk(irq, 1'b0);
    end
    // write-one clears only the written flags
    wr(`DEB_ADDR_ENABLE, 16'h0100);
    ev(3'b111);
    wr(`DEB_ADDR_REASON, 16'h1400);
    chk(irq, 1'b1);
    wr(`DEB_ADDR_REASON, 16'h0100);
    chk(irq, 1'b0);
    rdchk(`DEB_ADDR_REASON, 16'h0000);
    // bus reset clears like power-on
    ev(3'b001);
    // park the selection on a spare endpoint before the reset
    wr(`DEB_ADDR_ENDP, 16'h0007);
    @(posedge clk);
    bus_rst <= 1'b1;
    @(posedge clk);
    bus_rst <= 1'b0;
    #1;
    chk(irq, 1'b0);
    rdchk(`DEB_ADDR_ENABLE, 16'h0000);
    rdchk(`DEB_ADDR_ENDP, 16'h0000);
    rdchk(`DEB_ADDR_BURST, 16'h0004);
    rdchk(`DEB_ADDR_REASON, 16'h0000);
    // bursts in both bus modes, prompt and slow far side
    burst(16'h0004, 1'b1, 1'b0, 8'h02);
    burst(16'h0006, 1'b1, 1'b1, 8'h03);
    burst(16'h0005, 1'b0, 1'b1, 8'h05);
    burst(16'h0002, 1'b1, 1'b0, 8'h01);
    // bus reset in mid-burst drops the request and the length
    wr(`DEB_ADDR_BURST, 16'h0100);
    @(posedge clk);
    word_mode <= 1'b1;
    dma_run <= 1'b1;
    wait_req(1'b1);
    @(posedge clk);
    bus_rst <= 1'b1;
    @(posedge clk);
    bus_rst <= 1'b0;
    dma_run <= 1'b0;
    #1;
    chk(req, 1'b0);
    rdchk(`DEB_ADDR_BURST, 16'h0004);
    conclude();
  end
endmodule : tb_top
